// *** design/dsadc_seq.sv ***
// What this block does
// - Reference phase and idle phase derive from integration phase and synced comparator.
// - During idle phase hold integrator in comparator-error storing configuration.
// - Reference-phase pulse width signal gates the conversion counter.
// - Both integration and reference periods are counted in clock quanta.
// - Integration always lasts exactly the fixed full count of quanta.
// - Counter captures whole-quantum part of reference pulse as result.
// - Never latch count while comparator edge lies arbitrarily close to a quantum edge.
// - Comparator resynchronised to rising edge; synced compare ends phase, triggers latch.
// - Small remainder: synced compare follows after synchroniser delay minus remainder.
// - Large remainder: synced compare happens one quantum edge later.
// - Later-edge case: counter increments once more before latch.
// - Reference count reaching the limit or decade wrap detects over-range and drives overload output.
// - Integrator polarity sampled at end of integration, held until the next integration end, selects reference.
// - Resynchronising flip-flop samples comparator once per quantum on rising edge.
// - Buffer store presents latched count as 8421 BCD.
module dsadc_seq
  import dsadc_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             comparator_in,
  output logic                  integrate_sw_out,
  output logic                  ref_pos_sw_out,
  output logic                  ref_neg_sw_out,
  output logic                  idle_hold_out,
  output logic                  reference_pulse_out,
  output logic                  polarity_out,
  output logic [CNT_W-1:0]      result_bcd_out,
  output logic                  result_valid_out,
  output logic                  overload_out
);

  // Whole block state, one register
  typedef struct packed {
    logic [2:0]       cmp_sync;
    logic             cmp_q;
    logic             cmp_prev;
    logic [7:0]       div;
    dsadc_phase_t     phase;
    logic [CNT_W-1:0] cnt;
    logic             polarity;
    logic [CNT_W-1:0] bcd;
    logic             valid;
    logic             overload;
    logic             int_sw;
    logic             pos_sw;
    logic             neg_sw;
    logic             ref_sw;
    logic             idle_sw;
  } dsadc_state_t;

  dsadc_state_t st_ff;
  dsadc_state_t nxt_st;

  // Quantum tick and phase end conditions
  logic             quantum;
  logic             integ_done;
  logic             idle_done;
  logic             ref_limit;
  logic             crossed;
  logic             cmp_settled;

  // Decade counter for the reference phase
  logic [DIGITS:0]  carry;
  logic [CNT_W-1:0] bcd_inc;

  // One decade per loop pass, carry ripples upward
  genvar g;
  generate
    for (g = 0; g < DIGITS; g++) begin : g_dig
      // Current digit and its successor
      logic [3:0] digit;
      logic [3:0] digit_nxt;
      logic       is_nine;
      assign digit   = st_ff.cnt[4*g+3:4*g];
      assign is_nine = (digit == BCD_NINE);
      always_comb begin
        if (!carry[g]) begin
          digit_nxt = digit;
        end else if (is_nine) begin
          digit_nxt = 4'h0;
        end else begin
          digit_nxt = digit + 4'h1;
        end
      end
      assign bcd_inc[4*g+3:4*g] = digit_nxt;
      assign carry[g+1]         = carry[g] && is_nine;
    end
  endgenerate
  assign carry[0] = 1'b1;

  // Pin input settled when second and third stages agree
  assign cmp_settled = (st_ff.cmp_sync[2] == st_ff.cmp_sync[1]);
  // One quantum every QUANTUM_DIV clocks
  assign quantum     = (st_ff.div == QUANTUM_DIV - 8'h01);
  assign integ_done  = (st_ff.cnt == INTEGRATION_FULL_COUNT - 16'h0001);
  assign idle_done   = (st_ff.cnt == IDLE_COUNT - 16'h0001);
  // Over-range at the limit, or when the decade counter would wrap
  assign ref_limit   = (st_ff.cnt == REFERENCE_LIMIT) || carry[DIGITS];
  // Comparator flipped against the sense stored at integration end
  assign crossed     = (st_ff.cmp_q != st_ff.polarity);

  // Next state, one process
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.valid = 1'b0;

    // Three-stage comparator synchroniser
    nxt_st.cmp_sync = {st_ff.cmp_sync[1:0], comparator_in};
    if (cmp_settled) begin
      nxt_st.cmp_prev = st_ff.cmp_sync[2];
    end

    // Quantum divider
    if (quantum) begin
      nxt_st.div = 8'h00;
    end else begin
      nxt_st.div = st_ff.div + 8'h01;
    end

    // Phase sequencer, advanced once per quantum
    if (quantum) begin
      nxt_st.cmp_q = st_ff.cmp_prev;
      unique case (st_ff.phase)
        // Fixed-length integration
        DSADC_INTEG: begin
          if (integ_done) begin
            nxt_st.polarity = st_ff.cmp_prev;
            nxt_st.phase    = DSADC_REFER;
            nxt_st.cnt      = CNT_RST;
          end else begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
          end
        end

        // Reference until crossing or limit
        DSADC_REFER: begin
          // Crossing seen only at a quantum edge, so the count is settled
          if (crossed) begin
            // Late crossings already took their extra increment
            nxt_st.bcd      = st_ff.cnt;
            nxt_st.valid    = 1'b1;
            nxt_st.overload = 1'b0;
            nxt_st.phase    = DSADC_IDLE;
            nxt_st.cnt      = CNT_RST;
          end else if (ref_limit) begin
            nxt_st.overload = 1'b1;
            nxt_st.valid    = 1'b1;
            nxt_st.phase    = DSADC_IDLE;
            nxt_st.cnt      = CNT_RST;
          end else begin
            nxt_st.cnt = bcd_inc;
          end
        end

        // Integrator stores comparator error
        DSADC_IDLE: begin
          if (idle_done) begin
            nxt_st.phase = DSADC_INTEG;
            nxt_st.cnt   = CNT_RST;
          end else begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
          end
        end

        default: begin
          nxt_st.phase = DSADC_IDLE;
          nxt_st.cnt   = CNT_RST;
        end
      endcase
    end

    // Switch drive follows the phase about to be registered
    nxt_st.int_sw  = (nxt_st.phase == DSADC_INTEG);
    nxt_st.ref_sw  = (nxt_st.phase == DSADC_REFER);
    nxt_st.pos_sw  = nxt_st.ref_sw && nxt_st.polarity;
    nxt_st.neg_sw  = nxt_st.ref_sw && !nxt_st.polarity;
    nxt_st.idle_sw = (nxt_st.phase == DSADC_IDLE);
  end

  // Reset parks the sequencer in idle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      // Synchroniser, divider and sequencer
      st_ff.cmp_sync <= 3'h0;
      st_ff.cmp_q    <= 1'b0;
      st_ff.cmp_prev <= 1'b0;
      st_ff.div      <= 8'h00;
      st_ff.phase    <= DSADC_IDLE;
      st_ff.cnt      <= CNT_RST;
      st_ff.polarity <= 1'b0;
      // Result store
      st_ff.bcd      <= CNT_RST;
      st_ff.valid    <= 1'b0;
      st_ff.overload <= 1'b0;
      // Switches: only the idle hold closed
      st_ff.int_sw   <= 1'b0;
      st_ff.pos_sw   <= 1'b0;
      st_ff.neg_sw   <= 1'b0;
      st_ff.ref_sw   <= 1'b0;
      st_ff.idle_sw  <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign integrate_sw_out    = st_ff.int_sw;
  assign ref_pos_sw_out      = st_ff.pos_sw;
  assign ref_neg_sw_out      = st_ff.neg_sw;
  assign idle_hold_out       = st_ff.idle_sw;
  assign reference_pulse_out = st_ff.ref_sw;
  assign polarity_out        = st_ff.polarity;
  assign result_bcd_out      = st_ff.bcd;
  assign result_valid_out    = st_ff.valid;
  assign overload_out        = st_ff.overload;

endmodule

// *** design/dsadc_pkg.sv ***
package dsadc_pkg;
  localparam int unsigned CLK_HZ           = 20_000_000;
  localparam int unsigned DIGITS           = 4;
  localparam int unsigned CNT_W            = 4 * DIGITS;
  // Integration full count in quanta (design constant, plain default)
  localparam logic [CNT_W-1:0] INTEGRATION_FULL_COUNT = 16'h0400;
  // Reference phase longer than this many quanta is an over-range
  localparam logic [CNT_W-1:0] REFERENCE_LIMIT        = 16'h2000;
  // Idle phase length in quanta
  localparam logic [CNT_W-1:0] IDLE_COUNT             = 16'h0100;
  // Clock quantum divider: one quantum every QUANTUM_DIV clocks
  localparam logic [7:0]       QUANTUM_DIV            = 8'h0A;
  localparam logic [CNT_W-1:0] CNT_RST                = 16'h0000;
  localparam logic [3:0]       BCD_NINE               = 4'h9;

  typedef enum logic [2:0] {
    DSADC_INTEG = 3'b001,
    DSADC_REFER = 3'b010,
    DSADC_IDLE  = 3'b100
  } dsadc_phase_t;
endpackage

// *** sim/dsadc_seq_asserts.sv ***
module dsadc_seq_chk
  import dsadc_pkg::*;
(
  input wire logic             clk_in,
  input wire logic             rst_in,
  input wire logic             integrate_sw_out,
  input wire logic             ref_pos_sw_out,
  input wire logic             ref_neg_sw_out,
  input wire logic             idle_hold_out,
  input wire logic             reference_pulse_out,
  input wire logic             polarity_out,
  input wire logic [CNT_W-1:0] result_bcd_out,
  input wire logic             result_valid_out,
  input wire logic             overload_out
);
  timeunit 1ns / 1ns;
  // Clocks of one integration phase
  localparam int unsigned INTEG_CLKS = INTEGRATION_FULL_COUNT * QUANTUM_DIV;
  logic [17:0] cnt_ff;
  always_ff @(posedge clk_in) cnt_ff <= integrate_sw_out ? cnt_ff + 18'h0_0001 : 18'h0_0000;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_ref_pol: assert property (ref_pos_sw_out |-> polarity_out) else $error("pos");
  a_neg_pol: assert property (ref_neg_sw_out |-> !polarity_out) else $error("neg");
  a_phase_onehot: assert property ($onehot({integrate_sw_out, reference_pulse_out, idle_hold_out}))
    else $error("phase");
  a_idle_excl: assert property (reference_pulse_out |-> !idle_hold_out) else $error("idle");
  a_valid_end: assert property (result_valid_out |-> idle_hold_out) else $error("end");
  a_valid_one: assert property (result_valid_out |=> !result_valid_out) else $error("one");
  a_ovl_valid: assert property ($rose(overload_out) |-> result_valid_out) else $error("o");
  a_bcd_hold: assert property ($changed(result_bcd_out) |-> result_valid_out)
    else $error("hold");
  a_integ_len: assert property ($fell(integrate_sw_out) |-> cnt_ff == INTEG_CLKS)
    else $error("len");
  a_pulse_gate: assert property (reference_pulse_out == (ref_pos_sw_out | ref_neg_sw_out))
    else $error("gate");
  cover property ($rose(overload_out));
  cover property (result_valid_out && !overload_out);
  cover property ($fell(integrate_sw_out));
endmodule
bind dsadc_seq dsadc_seq_chk chk_u (.*);

// *** sim/dsadc_integ_model.sv ***
module dsadc_integ_model (
  input wire logic        clk_in,
  input wire logic        ref_in,
  input wire logic        sign_in,
  input wire logic [19:0] clks_in,
  output logic            comp_out
);
  timeunit 1ns / 1ns;
  logic [19:0] n_ff = 20'h0_0000;
  always @(posedge clk_in) n_ff <= (ref_in === 1'b1) ? n_ff + 20'h0_0001 : 20'h0_0000;
  assign comp_out = (ref_in === 1'b1 && n_ff >= clks_in) ? !sign_in : sign_in;
endmodule

// *** sim/dsadc_seq_bench.sv ***
module dsadc_seq_bench
  import dsadc_pkg::*;
;
  timeunit 1ns / 1ns;
  logic clk_in = 1'b0, rst_in = 1'b1, s = 1'b0, comp, refp, pol, valid, ovl;
  logic [15:0] bcd, first;
  logic [17:0] eq[$];
  int error_cnt = 0, checks = 0, q, c = 0;
  always #25 clk_in = !clk_in;
  dsadc_seq dut_u (.clk_in, .rst_in, .comparator_in(comp), .integrate_sw_out(),
    .ref_pos_sw_out(), .ref_neg_sw_out(), .idle_hold_out(), .reference_pulse_out(refp),
    .polarity_out(pol), .result_bcd_out(bcd), .result_valid_out(valid), .overload_out(ovl));
  dsadc_integ_model pm_u (.clk_in, .ref_in(refp), .sign_in(s), .clks_in(20'(c)), .comp_out(comp));
  task automatic chk(string n, logic [17:0] x, g);
    checks++;
    error_cnt += int'(x !== g);
    if (x !== g) $display("BAD %s exp %h got %h", n, x, g);
  endtask
  task stop_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(negedge clk_in) if (valid === 1'b1) begin
    if (eq.size() == 0) begin
      error_cnt++;
      $display("BAD res exp none got %h", {pol, ovl, bcd});
    end else begin
      chk("res", eq.pop_front(), {pol, ovl, bcd});
    end
  end
  task run_one(int cc, logic [17:0] x);
    {s, c} = {x[17], cc};
    eq.push_back(x);
    for (int i = 0; i < 40000 && eq.size() > 0; i++) @(negedge clk_in);
    chk("wait", 18'h0_0000, 18'(eq.size()));
    $display("test done, checks %0d", checks);
  endtask
  initial begin
    repeat (4) @(negedge clk_in);
    rst_in = 1'b0;
    q = $urandom(65667) % 1998 + 1;
    for (int i = 0; i < 4; i++) first[4*i+:4] = 4'((q + 1) / (10 ** i) % 10);
    run_one(q * int'(QUANTUM_DIV) + int'(QUANTUM_DIV) / 2, {q[0], 1'b0, first});
    run_one(32'h000F_FFFF, {!q[0], 1'b1, first});
    stop_test();
  end
endmodule
